/* hw/rbf_pkg.sv */
// Function
// RULE1: Thirteen programmer-visible registers in the core.
// RULE2: Data, address, frame registers form two banks.
// RULE3: Four 16-bit data registers for general operations.
// RULE4: First two data registers split into bytes.
// RULE5: Third/first and fourth/second pair to 32 bits.
// RULE6: Two 16-bit address registers, base or operand.
// RULE7: Address registers pair into one 32-bit register.
// RULE8: Frame base is 16 bits for frame addressing.
// RULE9: Vector table base is 20 bits wide.
// RULE10: Program counter is 20 bits, next instruction.
// RULE11: User and interrupt stack pointers, flag selects.
// RULE12: Static base is 16 bits for static addressing.
// RULE13: Bank flag zero selects bank zero, one bank one.
// RULE14: Flag register is 11 bits of processor state.
// RULE15: Banked writes touch only the selected bank.
package rbf_pkg;

	// ****************************************
	// Widths and bank layout.
	// ****************************************
	localparam int WORD_W = 16; // Width of a general register.
	localparam int WIDE_W = 20; // Width of table base and program counter.
	localparam int FLAG_W = 11; // Width of the flag register.
	localparam int BANK_N = 2; // Number of register banks.
	localparam int SLOT_N = 7; // Registers held in one bank.
	localparam int SLOT_DATA0 = 0; // Slot of the first data register.
	localparam int SLOT_DATA1 = 1; // Slot of the second data register.
	localparam int SLOT_DATA2 = 2; // Slot of the third data register.
	localparam int SLOT_DATA3 = 3; // Slot of the fourth data register.
	localparam int SLOT_ADDR0 = 4; // Slot of the first address register.
	localparam int SLOT_ADDR1 = 5; // Slot of the second address register.
	localparam int SLOT_FRAME = 6; // Slot of the frame base register.

	// ****************************************
	// Flag register fields and reset values.
	// ****************************************
	localparam int FLAG_BANK_BIT = 4; // Bank select flag position.
	localparam int FLAG_STACK_BIT = 7; // Stack select flag, one picks the user pointer.
	localparam logic [10:0] FLAG_RESET = 11'h000; // Flag register after reset.
	localparam logic [15:0] WORD_RESET = 16'h0000; // General registers after reset.
	localparam logic [19:0] WIDE_RESET = 20'h00000; // Wide registers after reset.

	// ****************************************
	// APB byte offsets, one aligned word each.
	// ****************************************
	localparam logic [7:0] OFS_DATA0 = 8'h00; // First data register.
	localparam logic [7:0] OFS_DATA1 = 8'h04; // Second data register.
	localparam logic [7:0] OFS_DATA2 = 8'h08; // Third data register.
	localparam logic [7:0] OFS_DATA3 = 8'h0c; // Fourth data register.
	localparam logic [7:0] OFS_ADDR0 = 8'h10; // First address register.
	localparam logic [7:0] OFS_ADDR1 = 8'h14; // Second address register.
	localparam logic [7:0] OFS_FRAME = 8'h18; // Frame base.
	localparam logic [7:0] OFS_VTB = 8'h1c; // Vector table base.
	localparam logic [7:0] OFS_PC = 8'h20; // Program counter.
	localparam logic [7:0] OFS_USP = 8'h24; // User stack pointer.
	localparam logic [7:0] OFS_ISP = 8'h28; // Interrupt stack pointer.
	localparam logic [7:0] OFS_SB = 8'h2c; // Static base.
	localparam logic [7:0] OFS_FLAG = 8'h30; // Flag register.
	localparam logic [7:0] OFS_PAIR_LOW = 8'h34; // Third over first data register.
	localparam logic [7:0] OFS_PAIR_HIGH = 8'h38; // Fourth over second data register.
	localparam logic [7:0] OFS_ADDR_PAIR = 8'h3c; // Second over first address register.

	// ****************************************
	// Register views that a request can name.
	// ****************************************
	typedef enum logic [4:0] {
		SEL_DATA0, SEL_DATA1, SEL_DATA2, SEL_DATA3,
		SEL_DATA0_HI, SEL_DATA0_LO, SEL_DATA1_HI, SEL_DATA1_LO,
		SEL_PAIR_LOW, SEL_PAIR_HIGH, SEL_ADDR0, SEL_ADDR1, SEL_ADDR_PAIR,
		SEL_FRAME, SEL_VTB, SEL_PC, SEL_USP, SEL_ISP, SEL_SP, SEL_SB, SEL_FLAG
	} rbf_sel_type;

	// Request from the instruction logic: one write and one read per cycle.
	typedef struct packed {
		logic wr_en;
		rbf_sel_type wr_sel;
		logic [31:0] wr_data;
		rbf_sel_type rd_sel;
	} rbf_core_req_type;

	// Effective write after arbitration between core and APB.
	typedef struct packed {
		logic go;
		rbf_sel_type sel;
		logic [31:0] data;
	} rbf_write_type;

endpackage

/* hw/rbf_regfile.sv */
module rbf_regfile (
	input wire logic i_clk,
	input wire logic i_rst_n,
	input wire rbf_pkg::rbf_core_req_type i_core,
	output logic [31:0] o_rd_data,
	output logic [19:0] o_pc,
	output logic [19:0] o_vtb,
	output logic [15:0] o_active_sp,
	output logic [15:0] o_frame_base,
	output logic [15:0] o_static_base,
	output logic [10:0] o_flag,
	input wire logic i_psel,
	input wire logic i_penable,
	input wire logic i_pwrite,
	input wire logic [7:0] i_paddr,
	input wire logic [31:0] i_pwdata,
	output logic [31:0] o_prdata,
	output logic o_pready,
	output logic o_pslverr
);
	import rbf_pkg::*;

	// ****************************************
	// Storage.
	// ****************************************

	// Two full copies of the banked working set.
	logic [15:0] bank_reg [BANK_N][SLOT_N];
	// Shared registers, one copy each.
	logic [19:0] vtb_reg;
	logic [19:0] pc_reg;
	logic [15:0] usp_reg;
	logic [15:0] isp_reg;
	logic [15:0] sb_reg;
	logic [10:0] flag_reg;
	// Registered read data toward the core and the bus.
	logic [31:0] rd_data_reg;
	logic [31:0] prdata_reg;
	logic err_reg;

	// Bank in use; the flag decides it for every banked access.
	logic bank_sel;
	assign bank_sel = flag_reg[FLAG_BANK_BIT]; // see RULE13

	// ****************************************
	// Read view.
	// ****************************************

	// Returns the value of a view in the selected bank, zero extended.
	function automatic logic [31:0] view(input rbf_sel_type s);
		logic [31:0] v;
		v = 32'h0000_0000;
		case (s)
			SEL_DATA0: v = {16'h0000, bank_reg[bank_sel][SLOT_DATA0]};
			SEL_DATA1: v = {16'h0000, bank_reg[bank_sel][SLOT_DATA1]};
			SEL_DATA2: v = {16'h0000, bank_reg[bank_sel][SLOT_DATA2]};
			SEL_DATA3: v = {16'h0000, bank_reg[bank_sel][SLOT_DATA3]};
			SEL_DATA0_HI: v = {24'h000000, bank_reg[bank_sel][SLOT_DATA0][15:8]};
			SEL_DATA0_LO: v = {24'h000000, bank_reg[bank_sel][SLOT_DATA0][7:0]};
			SEL_DATA1_HI: v = {24'h000000, bank_reg[bank_sel][SLOT_DATA1][15:8]};
			SEL_DATA1_LO: v = {24'h000000, bank_reg[bank_sel][SLOT_DATA1][7:0]};
			// Pairs put the higher-numbered register on top.
			SEL_PAIR_LOW: v = {bank_reg[bank_sel][SLOT_DATA2],
				bank_reg[bank_sel][SLOT_DATA0]}; // see RULE5
			SEL_PAIR_HIGH: v = {bank_reg[bank_sel][SLOT_DATA3],
				bank_reg[bank_sel][SLOT_DATA1]}; // see RULE5
			SEL_ADDR0: v = {16'h0000, bank_reg[bank_sel][SLOT_ADDR0]};
			SEL_ADDR1: v = {16'h0000, bank_reg[bank_sel][SLOT_ADDR1]};
			SEL_ADDR_PAIR: v = {bank_reg[bank_sel][SLOT_ADDR1],
				bank_reg[bank_sel][SLOT_ADDR0]}; // see RULE7
			SEL_FRAME: v = {16'h0000, bank_reg[bank_sel][SLOT_FRAME]};
			SEL_VTB: v = {12'h000, vtb_reg};
			SEL_PC: v = {12'h000, pc_reg};
			SEL_USP: v = {16'h0000, usp_reg};
			SEL_ISP: v = {16'h0000, isp_reg};
			SEL_SP: v = {16'h0000, o_active_sp};
			SEL_SB: v = {16'h0000, sb_reg};
			SEL_FLAG: v = {21'h000000, flag_reg};
			default: v = 32'h0000_0000;
		endcase
		return v;
	endfunction

	// ****************************************
	// APB decode.
	// ****************************************

	logic apb_hit;
	rbf_sel_type apb_sel;

	// Maps a bus offset onto a register view; anything else is unmapped.
	always_comb begin
		apb_hit = 1'b1;
		apb_sel = SEL_DATA0;
		case (i_paddr)
			OFS_DATA0: apb_sel = SEL_DATA0;
			OFS_DATA1: apb_sel = SEL_DATA1;
			OFS_DATA2: apb_sel = SEL_DATA2;
			OFS_DATA3: apb_sel = SEL_DATA3;
			OFS_ADDR0: apb_sel = SEL_ADDR0;
			OFS_ADDR1: apb_sel = SEL_ADDR1;
			OFS_FRAME: apb_sel = SEL_FRAME;
			OFS_VTB: apb_sel = SEL_VTB;
			OFS_PC: apb_sel = SEL_PC;
			OFS_USP: apb_sel = SEL_USP;
			OFS_ISP: apb_sel = SEL_ISP;
			OFS_SB: apb_sel = SEL_SB;
			OFS_FLAG: apb_sel = SEL_FLAG;
			OFS_PAIR_LOW: apb_sel = SEL_PAIR_LOW;
			OFS_PAIR_HIGH: apb_sel = SEL_PAIR_HIGH;
			OFS_ADDR_PAIR: apb_sel = SEL_ADDR_PAIR;
			default: apb_hit = 1'b0;
		endcase
	end

	// The bus waits while the core writes, so neither write is lost.
	assign o_pready = i_psel & i_penable & ~i_core.wr_en;
	assign o_pslverr = o_pready & err_reg;

	// ****************************************
	// Write arbitration.
	// ****************************************

	rbf_write_type wr;

	// The core has priority; a bus write only lands in its final access cycle.
	always_comb begin
		wr.go = 1'b0;
		wr.sel = i_core.wr_sel;
		wr.data = i_core.wr_data;
		if (i_core.wr_en) begin
			wr.go = 1'b1;
		end else if (o_pready && i_pwrite && apb_hit) begin
			wr.go = 1'b1;
			wr.sel = apb_sel;
			wr.data = i_pwdata;
		end
	end

	// ****************************************
	// Banked write decode.
	// ****************************************

	logic [15:0] slot_mask [SLOT_N];
	logic [15:0] slot_val [SLOT_N];

	// Each view becomes a bit mask and value per slot, so byte writes keep the other half.
	always_comb begin
		for (int i = 0; i < SLOT_N; i++) begin
			slot_mask[i] = 16'h0000;
			slot_val[i] = 16'h0000;
		end
		if (wr.go) begin
			case (wr.sel)
				// Full words of the four data registers.
				SEL_DATA0, SEL_DATA1, SEL_DATA2, SEL_DATA3: begin
					slot_mask[int'(wr.sel) - int'(SEL_DATA0)] = 16'hffff; // see RULE3
					slot_val[int'(wr.sel) - int'(SEL_DATA0)] = wr.data[15:0];
				end
				// Byte halves leave the opposite byte alone.
				SEL_DATA0_HI: begin
					slot_mask[SLOT_DATA0] = 16'hff00; // see RULE4
					slot_val[SLOT_DATA0] = {wr.data[7:0], 8'h00};
				end
				SEL_DATA0_LO: begin
					slot_mask[SLOT_DATA0] = 16'h00ff; // see RULE4
					slot_val[SLOT_DATA0] = {8'h00, wr.data[7:0]};
				end
				SEL_DATA1_HI: begin
					slot_mask[SLOT_DATA1] = 16'hff00; // see RULE4
					slot_val[SLOT_DATA1] = {wr.data[7:0], 8'h00};
				end
				SEL_DATA1_LO: begin
					slot_mask[SLOT_DATA1] = 16'h00ff; // see RULE4
					slot_val[SLOT_DATA1] = {8'h00, wr.data[7:0]};
				end
				// Data pairs: low half to the lower-numbered register.
				SEL_PAIR_LOW: begin
					slot_mask[SLOT_DATA0] = 16'hffff; // see RULE5
					slot_val[SLOT_DATA0] = wr.data[15:0];
					slot_mask[SLOT_DATA2] = 16'hffff;
					slot_val[SLOT_DATA2] = wr.data[31:16];
				end
				SEL_PAIR_HIGH: begin
					slot_mask[SLOT_DATA1] = 16'hffff; // see RULE5
					slot_val[SLOT_DATA1] = wr.data[15:0];
					slot_mask[SLOT_DATA3] = 16'hffff;
					slot_val[SLOT_DATA3] = wr.data[31:16];
				end
				// Address registers, alone or as a pair.
				SEL_ADDR0: begin
					slot_mask[SLOT_ADDR0] = 16'hffff; // see RULE6
					slot_val[SLOT_ADDR0] = wr.data[15:0];
				end
				SEL_ADDR1: begin
					slot_mask[SLOT_ADDR1] = 16'hffff; // see RULE6
					slot_val[SLOT_ADDR1] = wr.data[15:0];
				end
				SEL_ADDR_PAIR: begin
					slot_mask[SLOT_ADDR0] = 16'hffff; // see RULE7
					slot_val[SLOT_ADDR0] = wr.data[15:0];
					slot_mask[SLOT_ADDR1] = 16'hffff;
					slot_val[SLOT_ADDR1] = wr.data[31:16];
				end
				SEL_FRAME: begin
					slot_mask[SLOT_FRAME] = 16'hffff; // see RULE8
					slot_val[SLOT_FRAME] = wr.data[15:0];
				end
				// Shared views touch no bank slot.
				default: begin
				end
			endcase
		end
	end

	// ****************************************
	// Register updates.
	// ****************************************

	// Banked registers: only the copy in the selected bank changes.
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			for (int b = 0; b < BANK_N; b++) begin
				for (int i = 0; i < SLOT_N; i++) begin
					bank_reg[b][i] <= WORD_RESET; // see RULE2
				end
			end
		end else begin
			for (int i = 0; i < SLOT_N; i++) begin
				bank_reg[bank_sel][i] <= (bank_reg[bank_sel][i] & ~slot_mask[i])
					| (slot_val[i] & slot_mask[i]); // see RULE15
			end
		end
	end

	// Shared control and pointer registers; five plus flag and seven banked make thirteen.
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			vtb_reg <= WIDE_RESET;
			pc_reg <= WIDE_RESET;
			usp_reg <= WORD_RESET;
			isp_reg <= WORD_RESET;
			sb_reg <= WORD_RESET;
			flag_reg <= FLAG_RESET;
		end else if (wr.go) begin // see RULE1
			case (wr.sel)
				SEL_VTB: vtb_reg <= wr.data[19:0]; // see RULE9
				SEL_PC: pc_reg <= wr.data[19:0]; // see RULE10
				SEL_USP: usp_reg <= wr.data[15:0]; // see RULE11
				SEL_ISP: isp_reg <= wr.data[15:0]; // see RULE11
				// The active pointer view writes whichever pointer the flag picks.
				SEL_SP: begin
					if (flag_reg[FLAG_STACK_BIT]) begin
						usp_reg <= wr.data[15:0]; // see RULE11
					end else begin
						isp_reg <= wr.data[15:0];
					end
				end
				SEL_SB: sb_reg <= wr.data[15:0]; // see RULE12
				SEL_FLAG: flag_reg <= wr.data[10:0]; // see RULE14
				default: begin
				end
			endcase
		end
	end

	// Read data: the core sees its view one cycle later; the bus samples in every cycle that i_psel is high.
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			rd_data_reg <= 32'h0000_0000;
			prdata_reg <= 32'h0000_0000;
			err_reg <= 1'b0;
		end else begin
			rd_data_reg <= view(i_core.rd_sel);
			// Refreshing during a held access keeps read data current while the core stalls us.
			if (i_psel) begin
				prdata_reg <= apb_hit ? view(apb_sel) : 32'h0000_0000;
				err_reg <= ~apb_hit;
			end
		end
	end

	// ****************************************
	// Outputs.
	// ****************************************

	assign o_rd_data = rd_data_reg;
	assign o_prdata = prdata_reg;
	assign o_pc = pc_reg; // see RULE10
	assign o_vtb = vtb_reg; // see RULE9
	assign o_active_sp = flag_reg[FLAG_STACK_BIT] ? usp_reg : isp_reg; // see RULE11
	assign o_frame_base = bank_reg[bank_sel][SLOT_FRAME]; // see RULE8
	assign o_static_base = sb_reg; // see RULE12
	assign o_flag = flag_reg; // see RULE14

	// ****************************************
	// Assertions.
	// ****************************************

	// A plain core write of one view.
	sequence s_core_wr(rbf_sel_type s);
		i_core.wr_en && i_core.wr_sel == s;
	endsequence

	property p_other_bank_hold;
		@(posedge i_clk) disable iff (!i_rst_n)
		(wr.go && wr.sel != SEL_FLAG) |=> bank_reg[!$past(bank_sel)][SLOT_DATA0]
			== $past(bank_reg[!bank_sel][SLOT_DATA0]);
	endproperty
	a_other_bank_hold: assert property (p_other_bank_hold) // see RULE15
		else $error("Write disturbed the unselected bank.");

	// The upper byte takes the written byte while the lower byte keeps its old value.
	property p_high_byte_keeps_low;
		@(posedge i_clk) disable iff (!i_rst_n)
		s_core_wr(SEL_DATA0_HI) |=> bank_reg[$past(bank_sel)][SLOT_DATA0]
			== {$past(i_core.wr_data[7:0]), $past(bank_reg[bank_sel][SLOT_DATA0][7:0])};
	endproperty
	a_high_byte_keeps_low: assert property (p_high_byte_keeps_low) // see RULE4
		else $error("Upper byte write changed the lower byte.");

	property p_pair_low;
		@(posedge i_clk) disable iff (!i_rst_n)
		s_core_wr(SEL_PAIR_LOW) |=> {bank_reg[bank_sel][SLOT_DATA2],
			bank_reg[bank_sel][SLOT_DATA0]} == $past(i_core.wr_data);
	endproperty
	a_pair_low: assert property (p_pair_low) // see RULE5
		else $error("Low data pair write mismatch.");

	property p_addr_pair;
		@(posedge i_clk) disable iff (!i_rst_n)
		s_core_wr(SEL_ADDR_PAIR) |=> {bank_reg[bank_sel][SLOT_ADDR1],
			bank_reg[bank_sel][SLOT_ADDR0]} == $past(i_core.wr_data);
	endproperty
	a_addr_pair: assert property (p_addr_pair) // see RULE7
		else $error("Address pair write mismatch.");

	property p_pc_load;
		@(posedge i_clk) disable iff (!i_rst_n)
		s_core_wr(SEL_PC) |=> o_pc == $past(i_core.wr_data[19:0]);
	endproperty
	a_pc_load: assert property (p_pc_load) // see RULE10
		else $error("Program counter did not take the written value.");

	property p_vtb_load;
		@(posedge i_clk) disable iff (!i_rst_n)
		s_core_wr(SEL_VTB) ##1 !i_core.wr_en |=> o_vtb == $past(i_core.wr_data[19:0], 2);
	endproperty
	a_vtb_load: assert property (p_vtb_load) // see RULE9
		else $error("Vector table base lost its value.");

	// Writing the active-pointer view must land in the pointer that the flag picks.
	property p_stack_select;
		@(posedge i_clk) disable iff (!i_rst_n)
		s_core_wr(SEL_SP) |=> o_active_sp == $past(i_core.wr_data[15:0]);
	endproperty
	a_stack_select: assert property (p_stack_select) // see RULE11
		else $error("Active stack pointer does not follow the flag.");

	property p_bank_switch;
		@(posedge i_clk) disable iff (!i_rst_n)
		s_core_wr(SEL_FLAG) |=> bank_sel == $past(i_core.wr_data[FLAG_BANK_BIT]);
	endproperty
	a_bank_switch: assert property (p_bank_switch) // see RULE13
		else $error("Bank select did not follow the flag write.");

	property p_unmapped_error;
		@(posedge i_clk) disable iff (!i_rst_n)
		(i_psel && !i_penable && !apb_hit) ##1 (o_pready && $stable(i_paddr)) |-> o_pslverr;
	endproperty
	a_unmapped_error: assert property (p_unmapped_error)
		else $error("Unmapped bus access gave no error.");

endmodule

/* tb/testbench.sv */
module testbench;
	timeunit 1ns;
	timeprecision 1ns;
	import rbf_pkg::*;

	// ****************************************
	// Stimulus, outputs and the row table.
	// ****************************************
	// One row: a core write, then a core read whose answer is known.
	typedef struct packed {
		rbf_sel_type wsel;
		logic [31:0] wdata;
		rbf_sel_type rsel;
		logic [31:0] exp;
	} rbf_row_type;
	logic i_clk; // Core clock.
	logic i_rst_n; // Active low reset.
	rbf_core_req_type core_req; // Core request bundle.
	logic psel, penable, pwrite; // APB controls.
	logic [7:0] paddr; // APB address.
	logic [31:0] pwdata; // APB write data.
	logic [31:0] o_rd_data, o_prdata; // Read results.
	logic [19:0] o_pc, o_vtb; // Wide shared registers.
	logic [15:0] o_active_sp, o_frame_base, o_static_base; // Pointers and bases.
	logic [10:0] o_flag; // Flag register.
	logic o_pready, o_pslverr; // APB answer.
	int err_total = 0; // Mismatches seen.
	int tests_run = 0; // Comparisons made.
	rbf_row_type rows [15]; // Ordinary cases.
	logic [31:0] rd; // Last read value.
	logic er; // Last APB error flag.

	rbf_regfile u_rbf_regfile (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_core(core_req),
		.o_rd_data(o_rd_data), .o_pc(o_pc), .o_vtb(o_vtb), .o_active_sp(o_active_sp),
		.o_frame_base(o_frame_base), .o_static_base(o_static_base), .o_flag(o_flag),
		.i_psel(psel), .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr),
		.i_pwdata(pwdata), .o_prdata(o_prdata), .o_pready(o_pready), .o_pslverr(o_pslverr));

	// ****************************************
	// Shared tasks.
	// ****************************************
	// Compare one value and count it.
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			err_total++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	// Print the counts and the verdict, then stop.
	task automatic complete_run();
		$display("Comparisons %0d, mismatches %0d", tests_run, err_total);
		if (err_total == 0 && tests_run > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask

	// One core write: the strobe stands for exactly one edge.
	task automatic core_wr(input rbf_sel_type sel, input logic [31:0] d);
		@(posedge i_clk);
		core_req.wr_en <= 1'b1;
		core_req.wr_sel <= sel;
		core_req.wr_data <= d;
		@(posedge i_clk);
		core_req.wr_en <= 1'b0;
	endtask

	// One core read: the view is sampled at the next edge, then settles.
	task automatic core_rd(input rbf_sel_type sel, output logic [31:0] d);
		@(posedge i_clk);
		core_req.rd_sel <= sel;
		@(posedge i_clk);
		#1;
		d = o_rd_data;
	endtask

	// One APB transfer; the slave may stretch the access phase.
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
		output logic [31:0] r, output logic e);
		@(posedge i_clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= wd;
		@(posedge i_clk);
		penable <= 1'b1;
		// Only the watchdog ends a wait that never sees ready.
		do begin
			@(posedge i_clk);
		end while (o_pready !== 1'b1);
		r = o_prdata;
		e = o_pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		check({31'h0, o_pready}, 32'h1);
	endtask

	// ****************************************
	// Clock and watchdog.
	// ****************************************
	initial begin
		i_clk = 1'b0;
		forever #50 i_clk = ~i_clk;
	end

	// The whole run needs under two hundred cycles, so 5000 means a hang.
	initial begin
		#500000;
		err_total++;
		complete_run();
	end

	// ****************************************
	// Main sequence.
	// ****************************************
	initial begin
		i_rst_n = 1'b0;
		core_req = '0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		// Narrow registers must drop the high bits of the written word.
		rows = '{
			'{SEL_DATA0, 32'hffff1234, SEL_DATA0, 32'h00001234},
			'{SEL_DATA1, 32'ha5a55a5a, SEL_DATA1, 32'h00005a5a},
			'{SEL_DATA2, 32'h11112222, SEL_DATA2, 32'h00002222},
			'{SEL_DATA3, 32'h33334444, SEL_DATA3, 32'h00004444},
			'{SEL_ADDR0, 32'hdeadbeef, SEL_ADDR0, 32'h0000beef},
			'{SEL_ADDR1, 32'h0000cafe, SEL_ADDR_PAIR, 32'hcafebeef},
			'{SEL_FRAME, 32'h0000f00d, SEL_FRAME, 32'h0000f00d},
			'{SEL_VTB, 32'hffffffff, SEL_VTB, 32'h000fffff},
			'{SEL_PC, 32'h00123456, SEL_PC, 32'h00023456},
			'{SEL_SB, 32'h7777abcd, SEL_SB, 32'h0000abcd},
			'{SEL_PAIR_LOW, 32'h89abcdef, SEL_DATA2, 32'h000089ab},
			'{SEL_PAIR_HIGH, 32'h01020304, SEL_DATA1, 32'h00000304},
			'{SEL_DATA0_HI, 32'h0000009c, SEL_DATA0, 32'h00009cef},
			'{SEL_DATA1_LO, 32'h00000077, SEL_DATA1_HI, 32'h00000003},
			'{SEL_DATA0_LO, 32'h000000aa, SEL_PAIR_LOW, 32'h89ab9caa}
		};
		repeat (12) @(posedge i_clk);
		i_rst_n <= 1'b1;
		// Every mapped word reads zero after reset.
		for (int i = 0; i < 16; i++) begin
			apb(1'b0, 8'(4 * i), 32'h0, rd, er);
			check(rd, 32'h0);
		end
		check({21'h0, o_flag}, 32'h0);
		for (int i = 0; i < 15; i++) begin
			core_wr(rows[i].wsel, rows[i].wdata);
			core_rd(rows[i].rsel, rd);
			check(rd, rows[i].exp);
		end
		check({12'h0, o_pc}, 32'h00023456);
		check({12'h0, o_vtb}, 32'h000fffff);
		check({16'h0, o_static_base}, 32'h0000abcd);
		// Bank one starts clean and keeps bank zero apart.
		core_wr(SEL_FLAG, 32'h00000010);
		core_rd(SEL_DATA0, rd);
		check(rd, 32'h0);
		check({16'h0, o_frame_base}, 32'h0);
		core_wr(SEL_DATA0, 32'h00005555);
		core_wr(SEL_FLAG, 32'h0);
		core_rd(SEL_DATA0, rd);
		check(rd, 32'h00009caa);
		check({16'h0, o_frame_base}, 32'h0000f00d);
		core_wr(SEL_FLAG, 32'h00000010);
		core_rd(SEL_DATA0, rd);
		check(rd, 32'h00005555);
		// A pair write in bank one splits the word across both address registers.
		core_wr(SEL_ADDR_PAIR, 32'h12345678);
		core_rd(SEL_ADDR1, rd);
		check(rd, 32'h00001234);
		core_rd(SEL_ADDR0, rd);
		check(rd, 32'h00005678);
		// Stack pointer choice follows the stack flag.
		core_wr(SEL_USP, 32'h00001111);
		core_wr(SEL_ISP, 32'h00002222);
		core_wr(SEL_FLAG, 32'hffffffff);
		#1;
		check({21'h0, o_flag}, 32'h000007ff);
		core_rd(SEL_SP, rd);
		check(rd, 32'h00001111);
		core_wr(SEL_FLAG, 32'h0);
		#1;
		check({16'h0, o_active_sp}, 32'h00002222);
		// The active-pointer view writes the interrupt pointer and leaves the user one.
		core_wr(SEL_SP, 32'h00003333);
		#1;
		check({16'h0, o_active_sp}, 32'h00003333);
		core_rd(SEL_USP, rd);
		check(rd, 32'h00001111);
		// Register bus: mapped write, pair read, unmapped place.
		apb(1'b1, OFS_PC, 32'hfff12345, rd, er);
		#1;
		check({12'h0, o_pc}, 32'h00012345);
		apb(1'b0, OFS_ADDR_PAIR, 32'h0, rd, er);
		check(rd, 32'hcafebeef);
		apb(1'b1, 8'h40, 32'h12345678, rd, er);
		check({31'h0, er}, 32'h1);
		apb(1'b0, 8'h40, 32'h0, rd, er);
		check({er, rd[30:0]}, 32'h80000000);
		// A core write holds the bus off, so the bus write lands last.
		fork
			begin
				@(posedge i_clk);
				core_req.wr_en <= 1'b1;
				core_req.wr_sel <= SEL_SB;
				core_req.wr_data <= 32'h00001111;
				repeat (3) @(posedge i_clk);
				core_req.wr_en <= 1'b0;
			end
			apb(1'b1, OFS_SB, 32'h00002222, rd, er);
		join
		@(posedge i_clk);
		#1;
		check({16'h0, o_static_base}, 32'h00002222);
		// Reset in mid-run clears at once, without a clock edge.
		@(posedge i_clk);
		i_rst_n <= 1'b0;
		#1;
		check({12'h0, o_pc}, 32'h0);
		repeat (2) @(posedge i_clk);
		i_rst_n <= 1'b1;
		core_rd(SEL_DATA0, rd);
		check(rd, 32'h0);
		complete_run();
	end

endmodule
